/* verilog/lic_line_interface_config.sv */
// line interface configuration logic of an E1/T1 transceiver
// assumes framer status inputs on sys_clk, line pins asynchronous
// Notes on behaviour
// - T1 auto mode sends yellow on red
// - E1 auto mode sends RAI on loss
// - red alarm trunks data and signaling
// - out-of-frame trunks data only
// - trouble code on OOF when enabled and elastic store not bypassed
// - trunk conditioning beats trouble code
// - loss of signal inserts AIS, freezes
// - select digital or analog receive input
// - T1 violations, optional excessive zeros
// - E1 violations, zeros beyond four
// - optional digital receive data inversion
// - digital receive sampling edge select, bipolar samples on rising edge
// - bypass forty-bit attenuator delay
// - all-ones on selected output
// - all-ones gated by generator enable
// - pattern changeover keeps pulse alternation
// - alternating 0101 auxiliary pattern
// - loopback tap before pattern insertion
// - optional digital transmit inversion
// - digital mode, line held reset, Hi-Z
// - bipolar mode, digital outputs low
// - digital transmit update edge select
// - mode bit selects E1 or T1
`timescale 1ns/1ps
`default_nettype none
`include "lic_defs.svh"
module lic_line_interface_config (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic red_alarm,
  input wire logic oof,
  input wire logic los,
  input wire logic ais_det,
  input wire logic chan_data_trunk,
  input wire logic chan_sig_trunk,
  input wire logic rx_digital_data_in,
  input wire logic rx_digital_clock_in,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  input wire logic rx_line_clk,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic lcv_pulse,
  output logic tx_far_alarm,
  output logic tx_rai,
  output logic [1:0] rx_pcm_src,
  output logic rx_sig_trunk,
  output logic rx_ais_insert,
  output logic rx_sig_freeze,
  input wire logic tx_data_in,
  input wire logic tx_frame_in,
  output logic tx_bit_take,
  output logic loop_data,
  output logic tx_line_pos,
  output logic tx_line_neg,
  output logic tx_line_oe_n,
  output logic tx_line_reset,
  output logic tx_digital_data_out,
  output logic tx_digital_clock_out,
  output logic tx_frame_pulse_out
);
  // ********************
  // reset release
  // ********************
  logic rst_m_q, rst_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_q <= rst_m_q;
    end
  end

  // ********************
  // apb registers
  // ********************
  logic [7:0] rxcfg_q, txcfg_q, ctrl_q;
  logic [3:0] idx;
  logic acc, hit, wr;
  assign idx = paddr[5:2];
  assign acc = psel & penable & pready;
  assign hit = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
    (idx == `LIC_IDX_RXCFG || idx == `LIC_IDX_TXCFG || idx == `LIC_IDX_CTRL || idx == `LIC_IDX_STAT);
  assign wr = acc & pwrite & hit;
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      rxcfg_q <= `LIC_RXCFG_RST;
      txcfg_q <= `LIC_TXCFG_RST;
      ctrl_q <= `LIC_CTRL_RST;
    end else if (wr) begin
      if (idx == `LIC_IDX_RXCFG) rxcfg_q <= pwdata[7:0];
      if (idx == `LIC_IDX_TXCFG) txcfg_q <= pwdata[7:0] & `LIC_TXCFG_MASK;
      if (idx == `LIC_IDX_CTRL) ctrl_q <= pwdata[7:0];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      prdata <= 32'h0;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel & penable & ~pready & ~pwrite) begin
        case (idx)
          `LIC_IDX_RXCFG: prdata <= {24'h0, rxcfg_q};
          `LIC_IDX_TXCFG: prdata <= {24'h0, txcfg_q};
          `LIC_IDX_CTRL: prdata <= {24'h0, ctrl_q};
          `LIC_IDX_STAT: prdata <= {24'h0, rx_ais_insert, rx_sig_trunk, rx_pcm_src, tx_rai, tx_far_alarm,
            tx_line_reset, lcv_pulse};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ********************
  // receive alarm actions
  // ********************
  logic e1, pcm_trunk;
  assign e1 = ctrl_q[`LIC_B_STD_E1];
  assign pcm_trunk = chan_data_trunk | (rxcfg_q[`LIC_B_AUTO_RED] & red_alarm) |
    (rxcfg_q[`LIC_B_AUTO_OOF] & oof);
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      tx_far_alarm <= 1'b0;
      tx_rai <= 1'b0;
    end else begin
      tx_far_alarm <= ~e1 & ((rxcfg_q[`LIC_B_AUTO_FAR] & red_alarm) | ctrl_q[`LIC_B_MAN_YEL]);
      tx_rai <= e1 & ((rxcfg_q[`LIC_B_AUTO_FAR] & (oof | ais_det)) | ctrl_q[`LIC_B_MAN_RAI]);
    end
  end
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      rx_pcm_src <= lic_pkg::LIC_PCM_PASS;
      rx_sig_trunk <= 1'b0;
      rx_ais_insert <= 1'b0;
      rx_sig_freeze <= 1'b0;
    end else begin
      if (pcm_trunk) begin
        rx_pcm_src <= lic_pkg::LIC_PCM_TRUNK;
      end else if (oof & ctrl_q[`LIC_B_TRBL_EN] & ~ctrl_q[`LIC_B_ELST_BYP]) begin
        rx_pcm_src <= lic_pkg::LIC_PCM_TROUBLE;
      end else begin
        rx_pcm_src <= lic_pkg::LIC_PCM_PASS;
      end
      rx_sig_trunk <= chan_sig_trunk | (rxcfg_q[`LIC_B_AUTO_RED] & red_alarm);
      // AIS and freeze on loss of signal
      rx_ais_insert <= (rxcfg_q[`LIC_B_AUTO_AIS] & los) | ctrl_q[`LIC_B_MAN_MANUAL_RX_ALARM_INSERT];
      rx_sig_freeze <= rxcfg_q[`LIC_B_AUTO_AIS] & los;
    end
  end

  // ********************
  // receive input
  // ********************
  logic rck, dck1_q, dck2_q, lck1_q, lck2_q, rck3_q, rd1_q, rd2_q, rp1_q, rp2_q, rn1_q, rn2_q;
  logic dig, re, fe, strobe, mark, pos;
  logic [4:0] zr_q, thr;
  logic lpol_q, exz, bv, sig_ok;
  assign dig = rxcfg_q[`LIC_B_RX_DIG];
  assign rck = dig ? dck2_q : lck2_q;
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      {dck1_q, dck2_q, lck1_q, lck2_q, rck3_q, rd1_q, rd2_q, rp1_q, rp2_q, rn1_q, rn2_q} <= 11'h000;
    end else begin
      dck1_q <= rx_digital_clock_in;
      dck2_q <= dck1_q;
      lck1_q <= rx_line_clk;
      lck2_q <= lck1_q;
      rck3_q <= rck;
      rd1_q <= rx_digital_data_in;
      rd2_q <= rd1_q;
      rp1_q <= rx_line_pos;
      rp2_q <= rp1_q;
      rn1_q <= rx_line_neg;
      rn2_q <= rn1_q;
    end
  end
  assign re = rck & ~rck3_q;
  assign fe = ~rck & rck3_q;
  assign strobe = (dig & rxcfg_q[`LIC_B_RX_FALL]) ? fe : re;
  assign mark = dig ? (rd2_q ^ rxcfg_q[`LIC_B_RX_INV]) : (rp2_q | rn2_q);
  assign pos = rp2_q;
  assign thr = e1 ? `LIC_EXZ_E1 : (ctrl_q[`LIC_B_ZSUB] ? `LIC_EXZ_ZSUB : `LIC_EXZ_AMI);
  assign exz = ~mark & (zr_q == thr);
  assign bv = ~dig & mark & (pos == lpol_q);
  assign sig_ok = ctrl_q[`LIC_B_ZSUB] & ((zr_q == 5'h03) | (e1 ? (zr_q == 5'h02) : (zr_q == 5'h01)));
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      zr_q <= 5'h00;
      lpol_q <= 1'b0;
      rx_bit <= 1'b0;
      rx_bit_valid <= 1'b0;
      lcv_pulse <= 1'b0;
    end else begin
      rx_bit_valid <= strobe;
      lcv_pulse <= 1'b0;
      if (strobe) begin
        rx_bit <= mark;
        if (mark) begin
          zr_q <= 5'h00;
          lpol_q <= pos;
        end else if (zr_q != `LIC_ZR_MAX) begin
          zr_q <= zr_q + 5'h01;
        end
        lcv_pulse <= (bv & ~sig_ok) | (~rxcfg_q[`LIC_B_VIOL_ONLY] & exz);
      end
    end
  end

  // ********************
  // transmit path
  // ********************
  logic [1:0] ph_q;
  logic [`LIC_JAT_BITS-1:0] jat_q, fjat_q;
  logic take, src, fsrc, ones, alt, uni, mark_q, frm_q, aux_q, pol_q, mark_d;
  assign take = (ph_q == `LIC_PH_TAKE);
  assign uni = txcfg_q[`LIC_B_TX_DIG];
  assign ones = txcfg_q[`LIC_B_TX_ONES] & ctrl_q[`LIC_B_PG_AIS];
  assign alt = txcfg_q[`LIC_B_TX_ALT];
  assign src = txcfg_q[`LIC_B_TX_BYP] ? tx_data_in : jat_q[`LIC_JAT_BITS-1];
  assign fsrc = txcfg_q[`LIC_B_TX_BYP] ? tx_frame_in : fjat_q[`LIC_JAT_BITS-1];
  assign mark_d = ones ? 1'b1 : (alt ? aux_q : src);
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      jat_q <= '0;
      fjat_q <= '0;
      mark_q <= 1'b0;
      frm_q <= 1'b0;
      aux_q <= 1'b0;
      pol_q <= 1'b0;
      tx_bit_take <= 1'b0;
      loop_data <= 1'b0;
    end else begin
      tx_bit_take <= take;
      if (take) begin
        jat_q <= {jat_q[`LIC_JAT_BITS-2:0], tx_data_in};
        fjat_q <= {fjat_q[`LIC_JAT_BITS-2:0], tx_frame_in};
        loop_data <= src;
        mark_q <= mark_d;
        frm_q <= fsrc;
        aux_q <= alt & ~aux_q;
        if (mark_d) pol_q <= ~pol_q;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      tx_line_pos <= 1'b0;
      tx_line_neg <= 1'b0;
      tx_line_oe_n <= 1'b1;
      tx_line_reset <= 1'b1;
      tx_digital_data_out <= 1'b0;
      tx_digital_clock_out <= 1'b0;
      tx_frame_pulse_out <= 1'b0;
    end else begin
      tx_line_oe_n <= uni;
      tx_line_reset <= uni;
      if (!uni) begin
        tx_digital_data_out <= 1'b0;
        tx_digital_clock_out <= 1'b0;
        tx_frame_pulse_out <= 1'b0;
        if (ph_q == `LIC_PH_RISE) begin
          tx_line_pos <= mark_q & ~pol_q;
          tx_line_neg <= mark_q & pol_q;
        end else if (ph_q == `LIC_PH_FALL) begin
          tx_line_pos <= 1'b0;
          tx_line_neg <= 1'b0;
        end
      end else begin
        tx_line_pos <= 1'b0;
        tx_line_neg <= 1'b0;
        if (ph_q == `LIC_PH_RISE) tx_digital_clock_out <= 1'b1;
        if (ph_q == `LIC_PH_FALL) tx_digital_clock_out <= 1'b0;
        if (ph_q == (txcfg_q[`LIC_B_TX_RISE] ? `LIC_PH_RISE : `LIC_PH_FALL)) begin
          tx_digital_data_out <= mark_q ^ txcfg_q[`LIC_B_TX_INV];
          tx_frame_pulse_out <= frm_q;
        end
      end
    end
  end

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_q);
  sequence s_aux_on;
    alt & ~ones & take ##4 alt & ~ones & take;
  endsequence
  a_yellow_red: assert property (~e1 & rxcfg_q[7] & red_alarm |=> tx_far_alarm)
    else $error("yellow not sent on red");
  a_rai_loss: assert property (e1 & rxcfg_q[7] & oof |=> tx_rai && !tx_far_alarm)
    else $error("rai not sent on loss");
  a_red_trunk: assert property (rxcfg_q[6] & red_alarm |=> rx_pcm_src == 2'b01 && rx_sig_trunk)
    else $error("red trunk missing");
  a_oof_data: assert property (rxcfg_q[5] & oof & ~red_alarm & ~chan_sig_trunk |=> !rx_sig_trunk)
    else $error("oof touched signaling");
  a_trouble_prio: assert property (chan_data_trunk & oof |=> rx_pcm_src == 2'b01)
    else $error("trouble code beat trunk");
  a_ais_los: assert property (rxcfg_q[4] & los |=> rx_ais_insert && rx_sig_freeze)
    else $error("no AIS on loss of signal");
  a_ones_gate: assert property (take & ~ctrl_q[3] & ~alt |=> mark_q == $past(src))
    else $error("all-ones without enable");
  a_aux_toggle: assert property (s_aux_on |=> mark_q != $past(mark_q, 4))
    else $error("auxiliary pattern not toggling");
  a_no_double: assert property (tx_line_pos & ~$past(uni) |-> ##[1:8] tx_line_neg | uni | ~mark_q)
    else $error("pulse alternation broken");
  a_uni_quiet: assert property (uni |=> !tx_line_pos && !tx_line_neg && tx_line_oe_n)
    else $error("line driven in digital mode");
  a_bip_low: assert property (~uni |=> !tx_digital_data_out && !tx_frame_pulse_out)
    else $error("digital outputs not low");
  a_trouble_code: assert property (oof & ctrl_q[4] & ~ctrl_q[6] & ~pcm_trunk |=> rx_pcm_src == 2'b10)
    else $error("trouble code missing on out-of-frame");
  a_exz_count: assert property (strobe & ~mark & (zr_q == thr) & ~rxcfg_q[2] |=> lcv_pulse)
    else $error("excessive zeros not flagged");
  a_byp_path: assert property (take & txcfg_q[7] |=> loop_data == $past(tx_data_in))
    else $error("bypass path not direct");
  a_dig_clock: assert property (uni & (ph_q == 2'h3) |=> tx_digital_clock_out)
    else $error("digital clock not raised");
  a_upd_edge: assert property (uni & (ph_q != (txcfg_q[1] ? 2'h3 : 2'h1)) |=> $stable(tx_digital_data_out))
    else $error("digital output moved off its edge");
endmodule // lic_line_interface_config
`default_nettype wire

/* verilog/lic_defs.svh */
// register indices, field positions, reset values and counts
// assumes inclusion by bare name before use
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH
`define LIC_IDX_RXCFG 4'h3
`define LIC_IDX_TXCFG 4'h4
`define LIC_IDX_CTRL 4'h8
`define LIC_IDX_STAT 4'h9
`define LIC_RXCFG_RST 8'h00
`define LIC_TXCFG_RST 8'h00
`define LIC_CTRL_RST 8'h00
`define LIC_TXCFG_MASK 8'hFA
`define LIC_B_AUTO_FAR 7
`define LIC_B_AUTO_RED 6
`define LIC_B_AUTO_OOF 5
`define LIC_B_AUTO_AIS 4
`define LIC_B_RX_DIG 3
`define LIC_B_VIOL_ONLY 2
`define LIC_B_RX_INV 1
`define LIC_B_RX_FALL 0
`define LIC_B_TX_BYP 7
`define LIC_B_TX_ONES 6
`define LIC_B_TX_ALT 5
`define LIC_B_TX_INV 4
`define LIC_B_TX_DIG 3
`define LIC_B_TX_RISE 1
`define LIC_B_STD_E1 0
`define LIC_B_MAN_YEL 1
`define LIC_B_MAN_RAI 2
`define LIC_B_PG_AIS 3
`define LIC_B_TRBL_EN 4
`define LIC_B_MAN_MANUAL_RX_ALARM_INSERT 5
`define LIC_B_ELST_BYP 6
`define LIC_B_ZSUB 7
`define LIC_JAT_BITS 40
`define LIC_PH_TAKE 2'h2
`define LIC_PH_RISE 2'h3
`define LIC_PH_FALL 2'h1
`define LIC_EXZ_AMI 5'h0F
`define LIC_EXZ_ZSUB 5'h07
`define LIC_EXZ_E1 5'h04
`define LIC_ZR_MAX 5'h1F
`endif

/* verilog/lic_pkg.sv */
// types shared by the line interface config block
// assumes lic_defs.svh holds the numeric constants
package lic_pkg;
  typedef enum logic [1:0] {
    LIC_PCM_PASS = 2'b00,
    LIC_PCM_TRUNK = 2'b01,
    LIC_PCM_TROUBLE = 2'b10
  } lic_pcm_src_e;
endpackage

/* verification/lic_line_model.sv */
// line-side model driving the receive pins, digital and bipolar
// assumes the bench sets the receive config before a bit is sent
`timescale 1ns/1ps
`default_nettype none
module lic_line_model (
  output logic rx_digital_data_in,
  output logic rx_digital_clock_in,
  output logic rx_line_pos,
  output logic rx_line_neg,
  output logic rx_line_clk
);
  logic mark_q;
  initial begin
    {rx_digital_data_in, rx_digital_clock_in, rx_line_pos, rx_line_neg, rx_line_clk} = 5'h00;
    mark_q = 1'b0;
  end
  // one bit; data flips between edges so the sampling edge shows
  task automatic send(input logic b, input logic viol);
    #10;
    rx_digital_data_in = b;
    if (b) begin
      mark_q = viol ? mark_q : !mark_q;
      rx_line_pos = mark_q;
      rx_line_neg = !mark_q;
    end
    #400;
    rx_digital_clock_in = 1'b1;
    rx_line_clk = 1'b1;
    #400;
    rx_digital_data_in = !b;
    #400;
    rx_digital_clock_in = 1'b0;
    rx_line_clk = 1'b0;
    rx_line_pos = 1'b0;
    rx_line_neg = 1'b0;
    #400;
  endtask
endmodule // lic_line_model
`default_nettype wire

/* verification/test_line_interface_config.sv */
// self-checking bench for the line interface config block
// assumes the design files and lic_line_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "lic_defs.svh"
module test_line_interface_config;
  logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, rx_bit, rx_bit_valid, lcv_pulse, tx_far_alarm, tx_rai, rx_sig_trunk;
  logic red_alarm = 1'b0, oof = 1'b0, los = 1'b0, ais_det = 1'b0;
  logic chan_data_trunk = 1'b0, chan_sig_trunk = 1'b0, tx_data_in = 1'b0, tx_frame_in = 1'b0;
  logic rx_digital_data_in, rx_digital_clock_in, rx_line_pos, rx_line_neg, rx_line_clk;
  logic [1:0] rx_pcm_src;
  logic rx_ais_insert, rx_sig_freeze, tx_bit_take, loop_data, tx_line_pos, tx_line_neg;
  logic tx_line_oe_n, tx_line_reset, tx_digital_data_out, tx_digital_clock_out, tx_frame_pulse_out;
  int fail_count = 0, n_checks = 0, lcv_n = 0, nv = 0, np, nn, n1, nt, nl, nc, nk, nf, nb;
  localparam logic [7:0] A_RX = {2'h0, `LIC_IDX_RXCFG, 2'h0};
  localparam logic [7:0] A_TX = {2'h0, `LIC_IDX_TXCFG, 2'h0};
  localparam logic [7:0] A_CT = {2'h0, `LIC_IDX_CTRL, 2'h0};
  always #50 sys_clk = !sys_clk;
  lic_line_interface_config dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .red_alarm, .oof, .los, .ais_det, .chan_data_trunk, .chan_sig_trunk,
    .rx_digital_data_in, .rx_digital_clock_in, .rx_line_pos, .rx_line_neg, .rx_line_clk, .rx_bit,
    .rx_bit_valid, .lcv_pulse, .tx_far_alarm, .tx_rai, .rx_pcm_src, .rx_sig_trunk, .rx_ais_insert,
    .rx_sig_freeze, .tx_data_in, .tx_frame_in, .tx_bit_take, .loop_data, .tx_line_pos, .tx_line_neg,
    .tx_line_oe_n, .tx_line_reset, .tx_digital_data_out, .tx_digital_clock_out, .tx_frame_pulse_out);
  lic_line_model line (.rx_digital_data_in, .rx_digital_clock_in, .rx_line_pos, .rx_line_neg,
    .rx_line_clk);
  always @(posedge sys_clk) if (lcv_pulse === 1'b1) lcv_n++;
  always @(posedge sys_clk) if (rx_bit_valid === 1'b1) nv++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask
  task automatic t_regs;
    rd(A_RX, 32'h0, 1'b0);
    rd(A_TX, 32'h0, 1'b0);
    wr(A_RX, 8'hFF); wr(A_TX, 8'hFF);
    rd(A_RX, 32'hFF, 1'b0);
    rd(A_TX, 32'hFA, 1'b0);
    rd(8'h04, 32'h0, 1'b1);
    wr(A_RX, 8'h00); wr(A_TX, 8'h00);
    $display("done registers");
  endtask
  task automatic t_alarm;
    wr(A_CT, 8'h00); wr(A_RX, 8'h80);
    red_alarm <= 1'b1; ais_det <= 1'b1; repeat (3) @(posedge sys_clk);
    chk(tx_far_alarm, 1'b1); chk(tx_rai, 1'b0);
    wr(A_RX, 8'h00); chk(tx_far_alarm, 1'b0);
    wr(A_CT, 8'h02); chk(tx_far_alarm, 1'b1);
    red_alarm <= 1'b0; ais_det <= 1'b0; oof <= 1'b1;
    wr(A_CT, 8'h01); wr(A_RX, 8'h80);
    chk(tx_rai, 1'b1); chk(tx_far_alarm, 1'b0);
    oof <= 1'b0; ais_det <= 1'b1; repeat (3) @(posedge sys_clk);
    chk(tx_rai, 1'b1);
    ais_det <= 1'b0; repeat (3) @(posedge sys_clk);
    chk(tx_rai, 1'b0);
    wr(A_RX, 8'h00); wr(A_CT, 8'h05); chk(tx_rai, 1'b1);
    wr(A_CT, 8'h00);
    $display("done alarms");
  endtask
  task automatic t_trunk;
    wr(A_RX, 8'h40); red_alarm <= 1'b1; repeat (3) @(posedge sys_clk);
    chk(rx_pcm_src, lic_pkg::LIC_PCM_TRUNK); chk(rx_sig_trunk, 1'b1);
    red_alarm <= 1'b0; oof <= 1'b1; wr(A_RX, 8'h20);
    chk(rx_pcm_src, lic_pkg::LIC_PCM_TRUNK); chk(rx_sig_trunk, 1'b0);
    wr(A_RX, 8'h00); wr(A_CT, 8'h10);
    chk(rx_pcm_src, lic_pkg::LIC_PCM_TROUBLE);
    chan_data_trunk <= 1'b1; repeat (3) @(posedge sys_clk);
    chk(rx_pcm_src, lic_pkg::LIC_PCM_TRUNK);
    chan_data_trunk <= 1'b0; wr(A_CT, 8'h50);
    chk(rx_pcm_src, lic_pkg::LIC_PCM_PASS);
    oof <= 1'b0; wr(A_CT, 8'h00);
    wr(A_RX, 8'h10); los <= 1'b1; repeat (3) @(posedge sys_clk);
    chk({rx_ais_insert, rx_sig_freeze}, 2'h3);
    wr(A_RX, 8'h00); chk(rx_ais_insert, 1'b0);
    wr(A_CT, 8'h20); chk(rx_ais_insert, 1'b1);
    los <= 1'b0; wr(A_CT, 8'h00);
    $display("done trunk conditioning");
  endtask
  task automatic t_rx;
    logic [7:0] cfg [4] = '{8'h00, 8'h08, 8'h0A, 8'h09};
    logic b;
    int v0;
    foreach (cfg[i]) begin
      wr(A_RX, cfg[i]);
      for (int k = 0; k < 3; k++) begin
        b = (k != 1);
        v0 = nv;
        line.send(b, 1'b0);
        chk(rx_bit, b ^ (cfg[i][3] & (cfg[i][1] ^ cfg[i][0])));
        chk(nv - v0, 1);
      end
    end
    $display("done receive path");
  endtask
  task automatic zr(input int n, input int exp);
    int l0;
    line.send(1'b1, 1'b0);
    l0 = lcv_n;
    repeat (n) line.send(1'b0, 1'b0);
    line.send(1'b1, 1'b0);
    chk(lcv_n - l0, exp);
  endtask
  task automatic t_lcv;
    int l0;
    wr(A_RX, 8'h00); zr(15, 0); zr(16, 1);
    l0 = lcv_n; line.send(1'b1, 1'b1); repeat (4) @(posedge sys_clk);
    chk(lcv_n - l0, 1);
    wr(A_RX, 8'h04); zr(16, 0);
    wr(A_RX, 8'h00); wr(A_CT, 8'h01); zr(4, 0); zr(5, 1);
    wr(A_CT, 8'h80); zr(7, 0); zr(8, 1);
    l0 = lcv_n; repeat (3) line.send(1'b0, 1'b0);
    line.send(1'b1, 1'b1); line.send(1'b1, 1'b0);
    chk(lcv_n - l0, 0);
    wr(A_CT, 8'h00);
    $display("done violations");
  endtask
  task automatic obs;
    logic pp, pn, pd;
    {np, nn, n1, nt, nl, nc, nk, nf, nb} = '0;
    repeat (10) @(posedge sys_clk);
    {pp, pn, pd} = {tx_line_pos, tx_line_neg, tx_digital_data_out};
    repeat (32) begin
      @(posedge sys_clk);
      np += (tx_line_pos === 1'b1 && pp !== 1'b1);
      nn += (tx_line_neg === 1'b1 && pn !== 1'b1);
      n1 += (tx_digital_data_out === 1'b1);
      nt += (tx_digital_data_out !== pd);
      nc += (tx_digital_data_out !== pd && tx_digital_clock_out === 1'b1);
      nk += (tx_digital_clock_out === 1'b1);
      nf += (tx_frame_pulse_out === 1'b1);
      nb += (tx_bit_take === 1'b1);
      nl += (loop_data === 1'b1);
      {pp, pn, pd} = {tx_line_pos, tx_line_neg, tx_digital_data_out};
    end
  endtask
  task automatic t_tx;
    wr(A_CT, 8'h08); wr(A_TX, 8'hC8); obs;
    chk(n1, 32); chk(nl, 0); chk({tx_line_oe_n, tx_line_reset}, 2'h3);
    chk(nb, 8); chk(nk, 16);
    tx_frame_in <= 1'b1; wr(A_TX, 8'hD8); obs; chk(n1, 0); chk(nf, 32);
    wr(A_CT, 8'h00); wr(A_TX, 8'hC8); obs; chk(n1, 0);
    wr(A_TX, 8'hA8); obs; chk(nt, 8); chk(nc, 0);
    wr(A_TX, 8'hAA); obs; chk(nt, 8); chk(nc, 8);
    wr(A_CT, 8'h08); wr(A_TX, 8'hC0); obs;
    chk(np, 4); chk(nn, 4); chk(n1, 0); chk(nf, 0); chk(nk, 0); chk(tx_line_oe_n, 1'b0);
    wr(A_TX, 8'hA0); obs; chk(np + nn, 4);
    tx_frame_in <= 1'b0; tx_data_in <= 1'b1; wr(A_CT, 8'h00); wr(A_TX, 8'h08); obs; chk(n1, 0);
    repeat (160) @(posedge sys_clk); obs; chk(n1, 32); chk(nl, 32);
    tx_data_in <= 1'b0;
    $display("done transmit path");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #3000000;
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_regs; t_alarm; t_trunk; t_rx; t_lcv; t_tx;
    wrap_up;
  end
endmodule // test_line_interface_config
`default_nettype wire
